/* File: hdl/scpc_pkg.sv */
package scpc_pkg;

  // Channel protocol families
  localparam logic [1:0] PROTO_HDLC   = 2'h0;
  localparam logic [1:0] PROTO_ASYNC  = 2'h1;
  localparam logic [1:0] PROTO_BISYNC = 2'h2;

  // PPP variant field encodings
  localparam logic [1:0] PPP_NONE  = 2'h0;
  localparam logic [1:0] PPP_OCTET = 2'h1;
  localparam logic [1:0] PPP_ASYNC = 2'h2;
  localparam logic [1:0] PPP_BIT   = 2'h3;

  // HDLC sub-mode encodings
  localparam logic [1:0] SUBMODE_AUTO = 2'h0;
  localparam logic [1:0] SUBMODE_ADDR = 2'h2;

  // Sync character lengths in bits
  localparam logic [4:0] SYNC_MONO_SHORT = 5'h06;
  localparam logic [4:0] SYNC_MONO_LONG  = 5'h08;
  localparam logic [4:0] SYNC_BI_SHORT   = 5'h0C;
  localparam logic [4:0] SYNC_BI_LONG    = 5'h10;

  // Control field format in automode
  localparam logic [1:0] CTRL_BYTES_BASIC = 2'h1;
  localparam logic [1:0] CTRL_BYTES_EXT   = 2'h2;
  localparam logic [7:0] MODULUS_BASIC    = 8'h08;
  localparam logic [7:0] MODULUS_EXT      = 8'h80;

  // CRC
  localparam logic [15:0] CRC16_POLY     = 16'h1021;
  localparam logic [31:0] CRC32_POLY     = 32'h04C11DB7;
  localparam logic [31:0] CRC_ONES_16    = 32'h0000FFFF;
  localparam logic [31:0] CRC_ONES_32    = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_ZEROS      = 32'h00000000;
  localparam logic [2:0]  CRC_BYTES_16   = 3'h2;
  localparam logic [2:0]  CRC_BYTES_32   = 3'h4;
  localparam logic [5:0]  CRC_BITS_16    = 6'h10;
  localparam logic [5:0]  CRC_BITS_32    = 6'h20;

  // HDLC framing
  localparam logic [7:0] FLAG_BYTE    = 8'h7E;
  localparam logic [6:0] ABORT_RUN    = 7'h7F;
  localparam logic [2:0] STUFF_RUN    = 3'h5;
  localparam logic [3:0] FLAG_SKIP    = 4'h8;
  localparam logic [1:0] FLAGS_SHARED = 2'h1;
  localparam logic [1:0] FLAGS_SPLIT  = 2'h2;

  // Idle timeout: (length + 1) * 4 character frames
  localparam logic [13:0] TO_CHAR_MULT = 14'h0004;
  localparam logic [13:0] TO_ONE       = 14'h0001;

  typedef struct packed {
    logic [1:0] protocol;
    logic       response_mode_select;
    logic [1:0] ppp_variant_select;
    logic [1:0] hdlc_submode_select;
    logic       dual_sync_enable;
    logic       sync_char_length;
    logic       control_field_modulo;
    logic       internal_loopback;
    logic       flag_sharing_enable;
    logic       idle_timeout_enable;
    logic [6:0] idle_timeout_length;
    logic       crc_preset_select;
    logic       crc_width_select;
    logic [3:0] character_frame_length;
  } scpc_cfg_t;

  typedef struct packed {
    logic       lap_full_duplex;
    logic       lap_half_duplex;
    logic       ppp_active;
    logic [1:0] ppp_kind;
    logic [1:0] eff_submode;
    logic [4:0] sync_bits;
    logic [1:0] ctrl_bytes;
    logic [7:0] seq_modulus;
    logic [2:0] crc_bytes;
  } scpc_mode_t;

endpackage

/* File: hdl/scpc_crc.sv */
`timescale 1ns/1ps
`default_nettype none

module scpc_crc
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  input  wire logic        i_init,
  input  wire logic        i_preset_zero,
  input  wire logic        i_wide,
  input  wire logic        i_bit_en,
  input  wire logic        i_bit,
  output logic      [31:0] o_crc,
  output logic             o_zero
);

  logic [31:0] crc_q;
  logic [31:0] poly;
  logic [31:0] mask;
  logic [31:0] shifted;
  logic        fb;

  assign mask    = i_wide ? scpc_pkg::CRC_ONES_32 : scpc_pkg::CRC_ONES_16;
  assign poly    = i_wide ? scpc_pkg::CRC32_POLY : {16'h0000, scpc_pkg::CRC16_POLY}; // R17
  assign fb      = (i_wide ? crc_q[31] : crc_q[15]) ^ i_bit;
  assign shifted = {crc_q[30:0], 1'b0} ^ (fb ? poly : scpc_pkg::CRC_ZEROS);

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      crc_q <= scpc_pkg::CRC_ZEROS;
    else if (i_ce)
    begin
      if (i_init)
        crc_q <= i_preset_zero ? scpc_pkg::CRC_ZEROS : mask; // R16
      else if (i_bit_en)
        crc_q <= shifted & mask;
    end
  end

  assign o_crc  = crc_q;
  // Residue zero means a good frame, since the check bits go out unmodified
  assign o_zero = ((crc_q & mask) == scpc_pkg::CRC_ZEROS);

endmodule

`default_nettype wire

/* File: hdl/scpc_channel.sv */
// Overview of operation
// R1: Automode only: response mode clear gives full-duplex, set gives half-duplex response mode.
// R2: PPP variant 01 octet-sync, 10 async, 11 bit-sync PPP.
// R3: PPP variant 00 means no PPP; sub-mode comes from the sub-mode field.
// R4: Dual sync picks mono or bisync; sync length gives 6/12 or 8/16 bits.
// R5: Automode only: modulo bit picks one-byte mod 8 or two-byte mod 128 control.
// R6: Loopback feeds transmit data into the receiver right at the line pins.
// R7: In loopback transmit pin still driven, receive pin ignored.
// R8: Software picks a clock mode that lets looped data be received.
// R9: Software should avoid loopback in high-speed clock mode 4.
// R10: Flag sharing with a waiting frame uses one flag to close and open.
// R11: Receiver always accepts shared flags and flags sharing a zero bit.
// R12: Async timeout with processing enabled issues a receive flush command.
// R13: After flush the FIFO forwards below threshold; descriptor closes with block end.
// R14: No receive activity for the timeout period raises a timeout when enabled.
// R15: Timeout period is (length plus one) times four character frames; length is 7 bits.
// R16: CRC preset bit clear presets all ones, set presets all zeros.
// R17: CRC width bit picks 16-bit CCITT or 32-bit CRC for both directions.
// R18: Valid-frame check uses the CRC byte count of the chosen width.
// R19: Software sets the sub-mode field to address mode whenever PPP is used.
// R20: Software sets the bit clock rate option for async PPP.
// R21: Any received character restarts the idle timeout count.
`timescale 1ns/1ps
`default_nettype none

module scpc_channel
(
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_reset_n,
  input  wire logic                 i_clk_en,
  input  wire scpc_pkg::scpc_cfg_t  i_cfg,
  output scpc_pkg::scpc_mode_t      o_mode,
  output logic                      o_rx_flush_command,
  output logic                      o_rx_force_forward,
  input  wire logic                 i_rx_fifo_drained,
  output logic                      o_desc_close_block_end,
  input  wire logic                 i_line_clk,
  input  wire logic                 i_rxd,
  output logic                      o_txd,
  input  wire logic                 i_tx_valid,
  input  wire logic           [7:0] i_tx_byte,
  input  wire logic                 i_tx_last,
  input  wire logic                 i_tx_next_frame_pending,
  output logic                      o_tx_ready,
  input  wire logic                 i_rx_char_strobe,
  output logic                      o_rx_valid,
  output logic                [7:0] o_rx_byte,
  output logic                      o_rx_frame_end,
  output logic                      o_rx_frame_ok
);

  typedef enum logic [1:0] {TX_FLAG, TX_DATA, TX_CRC} scpc_tx_state_t;

  // ---------------- System clock domain: mode decode ----------------
  logic                 automode;
  scpc_pkg::scpc_mode_t mode_d;

  always_comb
  begin
    automode = (i_cfg.protocol == scpc_pkg::PROTO_HDLC)
               && (i_cfg.ppp_variant_select == scpc_pkg::PPP_NONE)
               && (i_cfg.hdlc_submode_select == scpc_pkg::SUBMODE_AUTO);
    mode_d = '0;
    mode_d.lap_full_duplex = automode && !i_cfg.response_mode_select; // R1
    mode_d.lap_half_duplex = automode && i_cfg.response_mode_select; // R1
    mode_d.ppp_active = (i_cfg.ppp_variant_select != scpc_pkg::PPP_NONE); // R2
    mode_d.ppp_kind = i_cfg.ppp_variant_select; // R2
    // PPP runs on the address sub-mode even if software left the field wrong
    mode_d.eff_submode = mode_d.ppp_active ? scpc_pkg::SUBMODE_ADDR
                                           : i_cfg.hdlc_submode_select; // R3
    case ({i_cfg.dual_sync_enable, i_cfg.sync_char_length}) // R4
      2'h0:    mode_d.sync_bits = scpc_pkg::SYNC_MONO_SHORT;
      2'h1:    mode_d.sync_bits = scpc_pkg::SYNC_MONO_LONG;
      2'h2:    mode_d.sync_bits = scpc_pkg::SYNC_BI_SHORT;
      default: mode_d.sync_bits = scpc_pkg::SYNC_BI_LONG;
    endcase
    if (automode)
    begin
      mode_d.ctrl_bytes  = i_cfg.control_field_modulo ? scpc_pkg::CTRL_BYTES_EXT
                                                      : scpc_pkg::CTRL_BYTES_BASIC; // R5
      mode_d.seq_modulus = i_cfg.control_field_modulo ? scpc_pkg::MODULUS_EXT
                                                      : scpc_pkg::MODULUS_BASIC; // R5
    end
    mode_d.crc_bytes = i_cfg.crc_width_select ? scpc_pkg::CRC_BYTES_32
                                              : scpc_pkg::CRC_BYTES_16; // R18
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_reset_n)
      o_mode <= '0;
    else if (i_clk_en)
      o_mode <= mode_d;
  end

  // ---------------- Crossings into the line clock domain ----------------
  // Configuration is quasi-static; change it only while the channel is idle
  scpc_pkg::scpc_cfg_t cfg_m;
  scpc_pkg::scpc_cfg_t cfg_s;
  logic                rst_m;
  logic                rst_s;
  logic                ce_m;
  logic                lce;

  always_ff @(posedge i_line_clk)
  begin
    cfg_m <= i_cfg;
    cfg_s <= cfg_m;
    rst_m <= i_reset_n;
    rst_s <= rst_m;
    ce_m  <= i_clk_en;
    lce   <= ce_m;
  end

  // ---------------- Transmit serializer ----------------
  scpc_tx_state_t tx_st;
  logic     [7:0] tx_sh;
  logic     [5:0] tx_bitcnt;
  logic     [2:0] tx_ones;
  logic     [1:0] tx_flags_left;
  logic           tx_last_q;
  logic           tx_stuff;
  logic           tx_take_flag;
  logic           tx_take_data;
  logic           tx_crc_bit;
  logic     [5:0] tx_crc_bits;
  logic    [31:0] tx_crc;
  logic     [4:0] tx_crc_idx;

  assign tx_stuff     = (tx_st != TX_FLAG) && (tx_ones == scpc_pkg::STUFF_RUN);
  assign tx_take_flag = lce && (tx_st == TX_FLAG) && (tx_bitcnt[2:0] == 3'h7)
                        && (tx_flags_left == scpc_pkg::FLAGS_SHARED) && i_tx_valid;
  assign tx_take_data = lce && (tx_st == TX_DATA) && !tx_stuff
                        && (tx_bitcnt[2:0] == 3'h7) && !tx_last_q && i_tx_valid;
  assign o_tx_ready   = tx_take_flag || tx_take_data;
  assign tx_crc_bits  = cfg_s.crc_width_select ? scpc_pkg::CRC_BITS_32 : scpc_pkg::CRC_BITS_16;
  assign tx_crc_idx   = 5'(tx_crc_bits - 6'h01 - tx_bitcnt);
  assign tx_crc_bit   = tx_crc[tx_crc_idx];

  always_ff @(posedge i_line_clk)
  begin
    if (!rst_s)
    begin
      tx_st         <= TX_FLAG;
      tx_sh         <= 8'h00;
      tx_bitcnt     <= 6'h00;
      tx_ones       <= 3'h0;
      tx_flags_left <= scpc_pkg::FLAGS_SHARED;
      tx_last_q     <= 1'b0;
      o_txd         <= 1'b1;
    end
    else if (lce)
    begin
      case (tx_st)
        TX_FLAG:
        begin
          o_txd   <= scpc_pkg::FLAG_BYTE[tx_bitcnt[2:0]];
          tx_ones <= 3'h0;
          if (tx_bitcnt[2:0] == 3'h7)
          begin
            tx_bitcnt <= 6'h00;
            if (tx_flags_left != scpc_pkg::FLAGS_SHARED)
              tx_flags_left <= tx_flags_left - 2'h1;
            else if (tx_take_flag)
            begin
              tx_st     <= TX_DATA;
              tx_sh     <= i_tx_byte;
              tx_last_q <= i_tx_last;
            end
          end
          else
            tx_bitcnt <= tx_bitcnt + 6'h01;
        end
        TX_DATA:
        begin
          if (tx_stuff)
          begin
            o_txd   <= 1'b0;
            tx_ones <= 3'h0;
          end
          else
          begin
            o_txd   <= tx_sh[0];
            tx_ones <= tx_sh[0] ? tx_ones + 3'h1 : 3'h0;
            tx_sh   <= {1'b0, tx_sh[7:1]};
            if (tx_bitcnt[2:0] == 3'h7)
            begin
              tx_bitcnt <= 6'h00;
              if (tx_take_data)
              begin
                tx_sh     <= i_tx_byte;
                tx_last_q <= i_tx_last;
              end
              else
                // An underrun closes the frame rather than stalling the line
                tx_st <= TX_CRC;
            end
            else
              tx_bitcnt <= tx_bitcnt + 6'h01;
          end
        end
        TX_CRC:
        begin
          if (tx_stuff)
          begin
            o_txd   <= 1'b0;
            tx_ones <= 3'h0;
          end
          else
          begin
            o_txd   <= tx_crc_bit;
            tx_ones <= tx_crc_bit ? tx_ones + 3'h1 : 3'h0;
            if (tx_bitcnt == tx_crc_bits - 6'h01)
            begin
              tx_st     <= TX_FLAG;
              tx_bitcnt <= 6'h00;
              tx_flags_left <= (cfg_s.flag_sharing_enable && i_tx_next_frame_pending)
                               ? scpc_pkg::FLAGS_SHARED : scpc_pkg::FLAGS_SPLIT; // R10
            end
            else
              tx_bitcnt <= tx_bitcnt + 6'h01;
          end
        end
        default: tx_st <= TX_FLAG;
      endcase
    end
  end

  scpc_crc u_tx_crc
  (
    .i_clk         (i_line_clk),
    .i_rst_n       (rst_s),
    .i_ce          (lce),
    .i_init        (tx_take_flag),
    .i_preset_zero (cfg_s.crc_preset_select), // R16
    .i_wide        (cfg_s.crc_width_select), // R17
    .i_bit_en      ((tx_st == TX_DATA) && !tx_stuff),
    .i_bit         (tx_sh[0]),
    .o_crc         (tx_crc),
    .o_zero        ()
  );

  // ---------------- Receive deframer ----------------
  logic       rxd_m;
  logic       rxd_s;
  logic       rx_bit;
  logic [7:0] rx_win;
  logic [7:0] rx_win_nx;
  logic       rx_flag;
  logic       rx_abort;
  logic [3:0] rx_skip;
  logic       rx_in_frame;
  logic       rx_end_pend;
  logic [2:0] rx_ones;
  logic [7:0] rx_sh;
  logic [2:0] rx_bitcnt;
  logic [7:0] rx_bytecnt;
  logic       rx_proc;
  logic       rx_drop;
  logic       rx_crc_zero;
  logic       rx_had_data;
  logic [2:0] rx_crc_need;

  always_ff @(posedge i_line_clk)
  begin
    rxd_m <= i_rxd;
    rxd_s <= rxd_m;
  end

  // Pin is ignored while looped; the looped bit is the one just driven out
  assign rx_bit    = cfg_s.internal_loopback ? o_txd : rxd_s; // R6 R7
  assign rx_win_nx = {rx_bit, rx_win[7:1]};
  // Window keeps its bits after a flag, so a zero can serve two flags
  assign rx_flag   = (rx_win_nx == scpc_pkg::FLAG_BYTE); // R11
  assign rx_abort  = (rx_win_nx[7:1] == scpc_pkg::ABORT_RUN);
  assign rx_proc   = rx_in_frame && (rx_skip == 4'h0) && !rx_end_pend;
  assign rx_drop   = !rx_win[0] && (rx_ones == scpc_pkg::STUFF_RUN);
  assign rx_had_data = (rx_bytecnt != 8'h00) || (rx_bitcnt != 3'h0);
  assign rx_crc_need = cfg_s.crc_width_select ? scpc_pkg::CRC_BYTES_32
                                              : scpc_pkg::CRC_BYTES_16; // R18

  always_ff @(posedge i_line_clk)
  begin
    if (!rst_s)
    begin
      rx_win         <= 8'h00;
      rx_skip        <= 4'h0;
      rx_in_frame    <= 1'b0;
      rx_end_pend    <= 1'b0;
      rx_ones        <= 3'h0;
      rx_sh          <= 8'h00;
      rx_bitcnt      <= 3'h0;
      rx_bytecnt     <= 8'h00;
      o_rx_valid     <= 1'b0;
      o_rx_byte      <= 8'h00;
      o_rx_frame_end <= 1'b0;
      o_rx_frame_ok  <= 1'b0;
    end
    else if (lce)
    begin
      rx_win         <= rx_win_nx;
      o_rx_valid     <= 1'b0;
      o_rx_frame_end <= 1'b0;
      if (rx_flag)
        rx_skip <= scpc_pkg::FLAG_SKIP; // R11
      else if (rx_skip != 4'h0)
        rx_skip <= rx_skip - 4'h1;
      if (rx_proc)
      begin
        if (rx_drop)
          rx_ones <= 3'h0;
        else
        begin
          rx_ones   <= rx_win[0] ? rx_ones + 3'h1 : 3'h0;
          rx_sh     <= {rx_win[0], rx_sh[7:1]};
          rx_bitcnt <= rx_bitcnt + 3'h1;
          if (rx_bitcnt == 3'h7)
          begin
            o_rx_valid <= 1'b1;
            o_rx_byte  <= {rx_win[0], rx_sh[7:1]};
            if (rx_bytecnt != 8'hFF)
              rx_bytecnt <= rx_bytecnt + 8'h01;
          end
        end
      end
      if (rx_end_pend)
      begin
        rx_end_pend    <= 1'b0;
        o_rx_frame_end <= rx_had_data;
        o_rx_frame_ok  <= rx_had_data && (rx_bitcnt == 3'h0) && rx_crc_zero
                          && (rx_bytecnt > {5'h00, rx_crc_need}); // R18
        rx_bytecnt     <= 8'h00;
        rx_bitcnt      <= 3'h0;
        rx_ones        <= 3'h0;
      end
      if (rx_abort)
      begin
        rx_in_frame <= 1'b0;
        rx_end_pend <= 1'b0;
        rx_bytecnt  <= 8'h00;
        rx_bitcnt   <= 3'h0;
      end
      else if (rx_flag)
      begin
        rx_in_frame <= 1'b1;
        rx_end_pend <= 1'b1;
      end
    end
  end

  scpc_crc u_rx_crc
  (
    .i_clk         (i_line_clk),
    .i_rst_n       (rst_s),
    .i_ce          (lce),
    .i_init        (rx_end_pend),
    .i_preset_zero (cfg_s.crc_preset_select), // R16
    .i_wide        (cfg_s.crc_width_select), // R17
    .i_bit_en      (rx_proc && !rx_drop),
    .i_bit         (rx_win[0]),
    .o_crc         (),
    .o_zero        (rx_crc_zero)
  );

  // ---------------- Async idle timeout ----------------
  logic [13:0] to_cnt;
  logic [13:0] to_limit;
  logic        to_armed;
  logic        to_toggle;
  logic        to_active;

  assign to_limit  = 14'((14'(cfg_s.idle_timeout_length) + scpc_pkg::TO_ONE)
                         * scpc_pkg::TO_CHAR_MULT * 14'(cfg_s.character_frame_length)); // R15
  assign to_active = (cfg_s.protocol == scpc_pkg::PROTO_ASYNC) && cfg_s.idle_timeout_enable;

  always_ff @(posedge i_line_clk)
  begin
    if (!rst_s)
    begin
      to_cnt    <= 14'h0000;
      to_armed  <= 1'b0;
      to_toggle <= 1'b0;
    end
    else if (lce)
    begin
      if (i_rx_char_strobe)
      begin
        to_cnt   <= 14'h0000; // R21
        to_armed <= 1'b1;
      end
      else if (to_armed && to_active)
      begin
        if (to_cnt >= to_limit - 14'h0001)
        begin
          to_toggle <= !to_toggle; // R14
          to_armed  <= 1'b0;
          to_cnt    <= 14'h0000;
        end
        else
          to_cnt <= to_cnt + 14'h0001;
      end
    end
  end

  // ---------------- Timeout event back to the system domain ----------------
  logic to_s1;
  logic to_s2;
  logic to_s3;
  logic to_event;

  always_ff @(posedge i_sys_clk)
  begin
    to_s1 <= to_toggle;
    to_s2 <= to_s1;
  end

  assign to_event = to_s2 ^ to_s3;

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_reset_n)
    begin
      to_s3                  <= 1'b0;
      o_rx_flush_command     <= 1'b0;
      o_rx_force_forward     <= 1'b0;
      o_desc_close_block_end <= 1'b0;
    end
    else if (i_clk_en)
    begin
      to_s3                  <= to_s2;
      o_rx_flush_command     <= to_event; // R12
      o_desc_close_block_end <= o_rx_flush_command; // R13
      // A new flush wins over a drain acknowledge in the same cycle
      if (to_event)
        o_rx_force_forward <= 1'b1; // R13
      else if (i_rx_fifo_drained)
        o_rx_force_forward <= 1'b0;
    end
  end

endmodule

`default_nettype wire

/* File: tb/scpc_checker.sv */
`timescale 1ns/1ps
`default_nettype none

module scpc_checker
(
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_reset_n,
  input  wire logic                 i_clk_en,
  input  wire scpc_pkg::scpc_cfg_t  i_cfg,
  input  wire scpc_pkg::scpc_mode_t o_mode,
  input  wire logic                 i_rx_fifo_drained,
  input  wire logic                 o_rx_flush_command,
  input  wire logic                 o_rx_force_forward,
  input  wire logic                 o_desc_close_block_end
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_reset_n);

  logic       hdlc;
  logic       auto;
  logic [4:0] sync_exp;

  assign hdlc = i_clk_en && i_cfg.protocol == scpc_pkg::PROTO_HDLC;
  assign auto = hdlc && i_cfg.ppp_variant_select == scpc_pkg::PPP_NONE
                && i_cfg.hdlc_submode_select == scpc_pkg::SUBMODE_AUTO;
  assign sync_exp = i_cfg.dual_sync_enable
                    ? (i_cfg.sync_char_length ? scpc_pkg::SYNC_BI_LONG : scpc_pkg::SYNC_BI_SHORT)
                    : (i_cfg.sync_char_length ? scpc_pkg::SYNC_MONO_LONG : scpc_pkg::SYNC_MONO_SHORT);

  AST_LAP_MODE: assert property (auto |=>
    o_mode.lap_half_duplex == $past(i_cfg.response_mode_select)
    && o_mode.lap_full_duplex != o_mode.lap_half_duplex) else $error("lap mode wrong");
  AST_PPP_KIND: assert property (hdlc |=> o_mode.ppp_kind == $past(i_cfg.ppp_variant_select)
    && o_mode.ppp_active == ($past(i_cfg.ppp_variant_select) != 2'h0)) else $error("ppp kind wrong");
  AST_SUBMODE: assert property (hdlc && i_cfg.ppp_variant_select == 2'h0 |=>
    o_mode.eff_submode == $past(i_cfg.hdlc_submode_select)) else $error("submode wrong");
  AST_SYNC_BITS: assert property (i_clk_en && i_cfg.protocol == scpc_pkg::PROTO_BISYNC |=>
    o_mode.sync_bits == $past(sync_exp)) else $error("sync length wrong");
  AST_MODULO: assert property (auto ##1 i_clk_en |->
    o_mode.seq_modulus == ($past(i_cfg.control_field_modulo) ? 8'h80 : 8'h08)) else $error("modulo wrong");
  AST_CRC_BYTES: assert property (i_clk_en |=>
    o_mode.crc_bytes == ($past(i_cfg.crc_width_select) ? 3'h4 : 3'h2)) else $error("crc bytes wrong");
  AST_FLUSH_CAUSE: assert property (o_rx_flush_command |->
    i_cfg.idle_timeout_enable && i_cfg.protocol == scpc_pkg::PROTO_ASYNC) else $error("stray flush");
  AST_CLOSE_AFTER: assert property (o_rx_flush_command |=>
    o_desc_close_block_end && o_rx_force_forward) else $error("no close after flush");
  AST_FWD_HOLD: assert property (i_clk_en && o_rx_force_forward && !i_rx_fifo_drained |=>
    o_rx_force_forward) else $error("forward dropped early");
endmodule

bind scpc_channel scpc_checker chk_u (.i_sys_clk, .i_reset_n, .i_clk_en, .i_cfg, .o_mode,
  .i_rx_fifo_drained, .o_rx_flush_command, .o_rx_force_forward, .o_desc_close_block_end);

`default_nettype wire

/* File: tb/scpc_line_peer.sv */
`timescale 1ns/1ps
`default_nettype none

module scpc_line_peer
(
  input  wire logic i_line_clk,
  output logic      o_rxd,
  output logic      o_char_strobe
);
  // Far pin changes every bit, so a leak past the test loop corrupts frames
  initial o_rxd = 1'h0;
  initial o_char_strobe = 1'h0;
  always @(negedge i_line_clk) o_rxd <= !o_rxd;

  task automatic send_char();
    @(negedge i_line_clk);
    o_char_strobe <= 1'h1;
    @(negedge i_line_clk);
    o_char_strobe <= 1'h0;
  endtask
endmodule

`default_nettype wire

/* File: tb/serial_channel_protocol_config_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module serial_channel_protocol_config_tb_top;
  logic i_sys_clk = 1'h0;
  logic i_line_clk = 1'h0;
  logic i_reset_n = 1'h0;
  logic i_rx_fifo_drained = 1'h0;
  logic i_tx_valid = 1'h0;
  logic i_tx_last = 1'h0;
  logic i_tx_next_frame_pending = 1'h0;
  logic [7:0] i_tx_byte = 8'h00;
  scpc_pkg::scpc_cfg_t i_cfg = '0;
  scpc_pkg::scpc_mode_t o_mode;
  logic o_flush, o_fwd, o_close, o_txd, o_tx_ready, o_rx_valid, o_fe, o_ok, rxd, strobe;
  logic [7:0] o_rx_byte;
  logic [15:0] rx_head;
  logic clk_en = 1'h1;
  logic [4:0] sync_tab [4] = '{scpc_pkg::SYNC_MONO_SHORT, scpc_pkg::SYNC_MONO_LONG,
                               scpc_pkg::SYNC_BI_SHORT, scpc_pkg::SYNC_BI_LONG};
  int fails = 0;
  int tests_run = 0;
  int fl_cnt = 0;
  int rx_cnt, fe_cnt, ok_cnt, tx_lo;

  always #50 i_sys_clk = !i_sys_clk;
  initial
  begin
    #1.3;
    forever #3 i_line_clk = !i_line_clk;
  end

  scpc_channel dut_u (.i_sys_clk, .i_reset_n, .i_clk_en(clk_en), .i_cfg, .o_mode,
    .o_rx_flush_command(o_flush), .o_rx_force_forward(o_fwd), .i_rx_fifo_drained,
    .o_desc_close_block_end(o_close), .i_line_clk, .i_rxd(rxd), .o_txd, .i_tx_valid, .i_tx_byte,
    .i_tx_last, .i_tx_next_frame_pending, .o_tx_ready, .i_rx_char_strobe(strobe), .o_rx_valid,
    .o_rx_byte, .o_rx_frame_end(o_fe), .o_rx_frame_ok(o_ok));
  scpc_line_peer peer_u (.i_line_clk, .o_rxd(rxd), .o_char_strobe(strobe));

  always @(negedge i_line_clk)
  begin
    if (o_rx_valid === 1'h1 && rx_cnt < 2)
      rx_head = {o_rx_byte, rx_head[15:8]};
    rx_cnt += (o_rx_valid === 1'h1);
    fe_cnt += (o_fe === 1'h1);
    ok_cnt += (o_fe === 1'h1 && o_ok === 1'h1);
    tx_lo += (o_txd === 1'h0);
  end
  always @(negedge i_sys_clk) fl_cnt += (o_flush === 1'h1);

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic bound(input int k, input int lim);
    if (k >= lim)
    begin
      fails++;
      close_out();
    end
  endtask

  task automatic cfg_set(input scpc_pkg::scpc_cfg_t c);
    @(negedge i_sys_clk);
    i_cfg = c;
    repeat (3) @(negedge i_sys_clk);
  endtask

  // Valid stays up between bytes; a gap mid-frame would end the frame
  task automatic send_byte(input logic [7:0] d, input logic last);
    int k;
    k = 0;
    i_tx_valid = 1'h1;
    i_tx_byte = d;
    i_tx_last = last;
    #1;
    while (o_tx_ready !== 1'h1 && k < 3000)
    begin
      @(negedge i_line_clk);
      k++;
    end
    bound(k, 3000);
    @(negedge i_line_clk);
  endtask

  task automatic t_modes();
    scpc_pkg::scpc_cfg_t c;
    logic [2:0] b;
    for (int i = 0; i < 8; i++)
    begin
      b = i[2:0];
      c = '0;
      {c.response_mode_select, c.control_field_modulo, c.crc_width_select} = b;
      cfg_set(c);
      check(o_mode.lap_half_duplex, b[2]);
      check(o_mode.lap_full_duplex, !b[2]);
      check(o_mode.ctrl_bytes, b[1] ? scpc_pkg::CTRL_BYTES_EXT : scpc_pkg::CTRL_BYTES_BASIC);
      check(o_mode.crc_bytes, b[0] ? scpc_pkg::CRC_BYTES_32 : scpc_pkg::CRC_BYTES_16);
      c.ppp_variant_select = b[1:0];
      c.hdlc_submode_select = (b[1:0] != 2'h0) ? scpc_pkg::SUBMODE_ADDR : 2'h1;
      cfg_set(c);
      check(o_mode.ppp_kind, b[1:0]);
      check(o_mode.eff_submode, c.hdlc_submode_select);
      c.protocol = scpc_pkg::PROTO_BISYNC;
      {c.dual_sync_enable, c.sync_char_length} = b[1:0];
      cfg_set(c);
      check(o_mode.sync_bits, sync_tab[b[1:0]]);
    end
    clk_en = 1'h0;
    c.crc_width_select = 1'h0;
    cfg_set(c);
    check(o_mode.crc_bytes, scpc_pkg::CRC_BYTES_32);
    clk_en = 1'h1;
    $display("t_modes done");
  endtask

  task automatic t_loop();
    scpc_pkg::scpc_cfg_t c;
    int k;
    for (int i = 0; i < 4; i++)
    begin
      c = '0;
      c.hdlc_submode_select = 2'h1;
      c.internal_loopback = 1'h1;
      c.crc_preset_select = i[0];
      c.flag_sharing_enable = i[0];
      c.crc_width_select = i[1];
      cfg_set(c);
      @(negedge i_line_clk);
      rx_cnt = 0;
      fe_cnt = 0;
      ok_cnt = 0;
      tx_lo = 0;
      i_tx_next_frame_pending = 1'h1;
      for (int f = 0; f < 2; f++)
      begin
        send_byte(8'h7E, 1'h0);
        send_byte(8'hFF, 1'h1);
        i_tx_valid = 1'h0;
        @(negedge i_line_clk);
      end
      i_tx_next_frame_pending = 1'h0;
      k = 0;
      while (fe_cnt < 2 && k < 1500)
      begin
        @(negedge i_line_clk);
        k++;
      end
      bound(k, 1500);
      repeat (40) @(negedge i_line_clk);
      check(fe_cnt, 2);
      check(ok_cnt, 2);
      check(rx_cnt, 2 * (i[1] ? 6 : 4));
      check(rx_head, 16'hFF7E);
      check(tx_lo != 0, 1);
    end
    $display("t_loop done");
  endtask

  task automatic t_tmo();
    scpc_pkg::scpc_cfg_t c;
    int f0;
    int k;
    c = '0;
    c.protocol = scpc_pkg::PROTO_ASYNC;
    c.idle_timeout_enable = 1'h1;
    c.idle_timeout_length = 7'h03;
    c.character_frame_length = 4'hA;
    cfg_set(c);
    f0 = fl_cnt;
    peer_u.send_char();
    repeat (120) @(negedge i_line_clk);
    peer_u.send_char();
    // Period is (3 + 1) * 4 * 10 = 160 line bits after the last character
    repeat (159) @(negedge i_line_clk);
    check(fl_cnt - f0, 0);
    k = 0;
    while (fl_cnt == f0 && k < 200)
    begin
      @(negedge i_line_clk);
      k++;
    end
    bound(k, 200);
    check(k > 40 && k < 62, 1);
    repeat (2) @(negedge i_sys_clk);
    check(o_fwd, 1'h1);
    i_rx_fifo_drained = 1'h1;
    @(negedge i_sys_clk);
    i_rx_fifo_drained = 1'h0;
    @(negedge i_sys_clk);
    check(o_fwd, 1'h0);
    c.idle_timeout_enable = 1'h0;
    cfg_set(c);
    peer_u.send_char();
    repeat (400) @(negedge i_line_clk);
    check(fl_cnt - f0, 1);
    $display("t_tmo done");
  endtask

  initial
  begin
    repeat (10) @(negedge i_sys_clk);
    i_reset_n = 1'h1;
    repeat (2) @(negedge i_sys_clk);
    t_modes();
    t_loop();
    t_tmo();
    close_out();
  end
endmodule

`default_nettype wire
